// ===== serial_baud_regs.vh
// register map, field layout and reset values of the baud/buffer block
// Function
// - a 2-bit field picks prescaler tap a, b, c or d for codes 00..11.
// - the selected tap is divided by N, codes 0001..1111 give 1..15, 0000 gives 16.
// - an enable bit (reset 0) switches the ratio from N to N+(16-K)/16.
// - with the fraction off any N from 1 to 16 is accepted; N=1 is for UART use only.
// - each channel has one 8-bit buffer address: writes feed transmit, reads give receive.
`ifndef SERIAL_BAUD_REGS_VH
`define SERIAL_BAUD_REGS_VH

// register indices; byte address on the bus is four times the index
`define SER0_BUF_IDX 32'hfffff230
`define SER5_BUF_IDX 32'hfffff290
`define BAUD5_CTRL_IDX 32'hfffff293
`define BAUD5_FRAC_IDX 32'hfffff294
`define STATUS_IDX 32'hfffff298

// decoded address width on the bus
`define ADDR_LSB_BITS 12

// control register fields
`define CTRL_FEN_BIT 6
`define CTRL_SEL_HI 5
`define CTRL_SEL_LO 4
`define CTRL_DIV_HI 3
`define CTRL_DIV_LO 0

// fraction register field
`define FRAC_K_HI 3
`define FRAC_K_LO 0

// status register fields
`define ST_RX0_FULL 0
`define ST_TX0_EMPTY 1
`define ST_TX0_FULL 2
`define ST_RX5_FULL 4
`define ST_TX5_EMPTY 5
`define ST_TX5_FULL 6

// reset values
`define CTRL_RESET 8'h00
`define FRAC_RESET 4'h0
`define RXBUF_RESET 8'h00

// tap select codes
`define SEL_TAP_A 2'h0
`define SEL_TAP_B 2'h1
`define SEL_TAP_C 2'h2
`define SEL_TAP_D 2'h3

// fraction period count and bus responses
`define FRAC_PERIODS 5'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== byte_fifo.v
// synchronous fifo of flip-flops with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // fill side
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // drain side
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  // levels
  output wire empty,
  output wire full
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign full = (count == DEPTH[AW:0]);
  assign empty = (count == {(AW+1){1'b0}});
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr];
  assign push = in_valid & ~full;
  assign pop = out_ready & ~empty;

  // storage needs no reset; empty gates the output
  always @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap at depth, which is a power of two
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // byte_fifo
`default_nettype wire

// ===== serial_baud_divider_and_buffer.v
// baud rate generator and serial data buffers behind an axi4-lite slave
`timescale 1ns/10ps
`default_nettype none
`include "serial_baud_regs.vh"
module serial_baud_divider_and_buffer #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // prescaler tap enables, one-cycle pulses on aclk
  input wire prescale_tap_a,
  input wire prescale_tap_b,
  input wire prescale_tap_c,
  input wire prescale_tap_d,
  // baud clock enable to the channel 5 serial engine
  output reg baud5_tick,
  // channel 0 transmit bytes to the serial engine
  output wire [7:0] tx0_data,
  output wire tx0_valid,
  input wire tx0_ready,
  // channel 0 received bytes from the serial engine
  input wire [7:0] rx0_data,
  input wire rx0_valid,
  // channel 5 transmit bytes to the serial engine
  output wire [7:0] tx5_data,
  output wire tx5_valid,
  input wire tx5_ready,
  // channel 5 received bytes from the serial engine
  input wire [7:0] rx5_data,
  input wire rx5_valid
);
  localparam [31:0] A_SER0 = `SER0_BUF_IDX << 2;
  localparam [31:0] A_SER5 = `SER5_BUF_IDX << 2;
  localparam [31:0] A_CTRL = `BAUD5_CTRL_IDX << 2;
  localparam [31:0] A_FRAC = `BAUD5_FRAC_IDX << 2;
  localparam [31:0] A_STAT = `STATUS_IDX << 2;
  localparam [7:0] CTRL_RST = `CTRL_RESET;

  // register state
  reg fraction_enable;
  reg [1:0] input_clock_select;
  reg [3:0] divisor_n;
  reg [3:0] fraction_k;
  reg [7:0] rx0_byte;
  reg [7:0] rx5_byte;
  reg rx0_full;
  reg rx5_full;

  // write channel holding registers
  reg aw_held;
  reg w_held;
  reg [`ADDR_LSB_BITS-1:0] aw_addr;
  reg [7:0] w_byte;
  reg w_lane0;

  // divider state
  reg [4:0] div_count;
  reg [3:0] frac_phase;
  reg tap_pulse;
  reg [4:0] period_last;
  reg stretch;
  reg [4:0] stretch_count;

  // fifo wiring
  wire tx0_in_ready;
  wire tx5_in_ready;
  wire tx0_empty;
  wire tx0_full;
  wire tx5_empty;
  wire tx5_full;

  // write decode
  wire wr_ser0 = (aw_addr == A_SER0[`ADDR_LSB_BITS-1:0]);
  wire wr_ser5 = (aw_addr == A_SER5[`ADDR_LSB_BITS-1:0]);
  wire wr_ctrl = (aw_addr == A_CTRL[`ADDR_LSB_BITS-1:0]);
  wire wr_frac = (aw_addr == A_FRAC[`ADDR_LSB_BITS-1:0]);
  wire wr_stat = (aw_addr == A_STAT[`ADDR_LSB_BITS-1:0]);
  wire wr_hit = wr_ser0 | wr_ser5 | wr_ctrl | wr_frac | wr_stat;

  // a buffer write waits while its fifo is full: that stalls the bus
  wire wr_blocked = (wr_ser0 & ~tx0_in_ready) | (wr_ser5 & ~tx5_in_ready);
  wire do_write = aw_held & w_held & ~s_axi_bvalid & ~wr_blocked;
  wire wr_en = do_write & w_lane0;
  wire push0 = wr_en & wr_ser0;
  wire push5 = wr_en & wr_ser5;

  // read decode
  wire [`ADDR_LSB_BITS-1:0] ar_addr = s_axi_araddr[`ADDR_LSB_BITS-1:0];
  wire rd_ser0 = (ar_addr == A_SER0[`ADDR_LSB_BITS-1:0]);
  wire rd_ser5 = (ar_addr == A_SER5[`ADDR_LSB_BITS-1:0]);
  wire rd_ctrl = (ar_addr == A_CTRL[`ADDR_LSB_BITS-1:0]);
  wire rd_frac = (ar_addr == A_FRAC[`ADDR_LSB_BITS-1:0]);
  wire rd_stat = (ar_addr == A_STAT[`ADDR_LSB_BITS-1:0]);
  wire rd_take = s_axi_arvalid & s_axi_arready;

  // transmit fifos, one per channel
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_tx0_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(w_byte),
    .in_valid(push0),
    .in_ready(tx0_in_ready),
    .out_data(tx0_data),
    .out_valid(tx0_valid),
    .out_ready(tx0_ready),
    .empty(tx0_empty),
    .full(tx0_full)
  );

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_tx5_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(w_byte),
    .in_valid(push5),
    .in_ready(tx5_in_ready),
    .out_data(tx5_data),
    .out_valid(tx5_valid),
    .out_ready(tx5_ready),
    .empty(tx5_empty),
    .full(tx5_full)
  );

  // write address and data are taken independently, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`ADDR_LSB_BITS{1'b0}};
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[`ADDR_LSB_BITS-1:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // generator control and fraction registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      fraction_enable <= CTRL_RST[`CTRL_FEN_BIT];
      input_clock_select <= CTRL_RST[`CTRL_SEL_HI:`CTRL_SEL_LO];
      divisor_n <= CTRL_RST[`CTRL_DIV_HI:`CTRL_DIV_LO];
      fraction_k <= `FRAC_RESET;
    end else if (wr_en & wr_ctrl) begin
      // top bit has no storage, software keeps it 0
      fraction_enable <= w_byte[`CTRL_FEN_BIT];
      input_clock_select <= w_byte[`CTRL_SEL_HI:`CTRL_SEL_LO];
      divisor_n <= w_byte[`CTRL_DIV_HI:`CTRL_DIV_LO];
    end else if (wr_en & wr_frac) begin
      fraction_k <= w_byte[`FRAC_K_HI:`FRAC_K_LO];
    end
  end

  // receive holding bytes; a new byte wins over the clear by a read
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx0_byte <= `RXBUF_RESET;
      rx5_byte <= `RXBUF_RESET;
      rx0_full <= 1'b0;
      rx5_full <= 1'b0;
    end else begin
      if (rx0_valid) begin
        rx0_byte <= rx0_data;
        rx0_full <= 1'b1;
      end else if (rd_take & rd_ser0) begin
        rx0_full <= 1'b0;
      end
      if (rx5_valid) begin
        rx5_byte <= rx5_data;
        rx5_full <= 1'b1;
      end else if (rd_take & rd_ser5) begin
        rx5_full <= 1'b0;
      end
    end
  end

  // read channel: one read at a time, answer one cycle after address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      if (rd_ser0) begin
        s_axi_rdata <= {24'h000000, rx0_byte};
      end else if (rd_ser5) begin
        s_axi_rdata <= {24'h000000, rx5_byte};
      end else if (rd_ctrl) begin
        s_axi_rdata <= {25'h0000000, fraction_enable,
                        input_clock_select, divisor_n};
      end else if (rd_frac) begin
        s_axi_rdata <= {28'h0000000, fraction_k};
      end else if (rd_stat) begin
        s_axi_rdata <= {25'h0000000, tx5_full, tx5_empty, rx5_full,
                        1'b0, tx0_full, tx0_empty, rx0_full};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_SLVERR;
      end
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // tap select
  always @* begin
    case (input_clock_select)
      `SEL_TAP_A: tap_pulse = prescale_tap_a;
      `SEL_TAP_B: tap_pulse = prescale_tap_b;
      `SEL_TAP_C: tap_pulse = prescale_tap_c;
      `SEL_TAP_D: tap_pulse = prescale_tap_d;
      default: tap_pulse = 1'b0;
    endcase
  end

  // stretch (16-K) of every 16 periods; divisor code 0 wraps to 16
  always @* begin
    stretch_count = `FRAC_PERIODS - {1'b0, fraction_k};
    stretch = fraction_enable &
              ({1'b0, frac_phase} < stretch_count);
    period_last = {1'b0, divisor_n - 4'h1} + {4'h0, stretch};
  end

  // divider counts tap pulses; N=1 with the fraction off ticks on every tap pulse
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_count <= 5'h00;
      frac_phase <= 4'h0;
      baud5_tick <= 1'b0;
    end else begin
      baud5_tick <= 1'b0;
      if (wr_en & wr_ctrl) begin
        // restart cleanly on a new setting
        div_count <= 5'h00;
        frac_phase <= 4'h0;
      end else if (tap_pulse) begin
        if (div_count >= period_last) begin
          div_count <= 5'h00;
          baud5_tick <= 1'b1;
          frac_phase <= frac_phase + 4'h1;
        end else begin
          div_count <= div_count + 5'h01;
        end
      end
    end
  end
endmodule // serial_baud_divider_and_buffer
`default_nettype wire

// ===== serial_baud_divider_and_buffer_sva.sv
// assertion checker for the baud/buffer block bus and tick ports
`timescale 1ns/10ps
`default_nettype none
module serial_baud_divider_and_buffer_sva (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_awready,
  input wire s_axi_wready,
  // generator and channel 0 transmit
  input wire prescale_tap_a,
  input wire prescale_tap_b,
  input wire prescale_tap_c,
  input wire prescale_tap_d,
  input wire baud5_tick,
  input wire [7:0] tx0_data,
  input wire tx0_valid,
  input wire tx0_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // reads always answer on the next edge
  a_r_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // holes in the map must answer with an error and zero data
  a_r_unmapped: assert property (
    s_axi_arvalid && s_axi_arready && !(s_axi_araddr[11:0] inside
    {12'h8c0, 12'ha40, 12'ha4c, 12'ha50, 12'ha60})
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_b_order: assert property (
    $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("response before address and data");
  // a tick only ever follows some prescaler pulse
  a_tick_has_tap: assert property (baud5_tick |-> $past(prescale_tap_a |
    prescale_tap_b | prescale_tap_c | prescale_tap_d))
    else $error("tick without tap");
  a_tx_hold: assert property (
    tx0_valid && !tx0_ready |=> tx0_valid && $stable(tx0_data))
    else $error("transmit head changed");
endmodule // serial_baud_divider_and_buffer_sva
bind serial_baud_divider_and_buffer serial_baud_divider_and_buffer_sva u_sva (.*);
`default_nettype wire

// ===== test_serial_baud_divider_and_buffer.sv
// self-checking bench for the baud generator and serial buffers
`timescale 1ns/10ps
`default_nettype none
`include "serial_baud_regs.vh"
module test_serial_baud_divider_and_buffer;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, baud5_tick;
  logic tx0_valid, tx0_ready, tx5_valid, tx5_ready, rx0_valid, rx5_valid;
  logic slow; // holds bready/rready back so the answer must stand
  logic prescale_tap_a, prescale_tap_b, prescale_tap_c, prescale_tap_d;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb, tap;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] tx0_data, tx5_data, rx0_data, rx5_data;
  integer errors = 0, n_tests = 0, ticks = 0, i;
  localparam [31:0] A0 = `SER0_BUF_IDX << 2;
  localparam [31:0] A5 = `SER5_BUF_IDX << 2;
  localparam [31:0] CT = `BAUD5_CTRL_IDX << 2;
  localparam [31:0] FR = `BAUD5_FRAC_IDX << 2;
  localparam [31:0] ST = `STATUS_IDX << 2;
  assign {prescale_tap_d, prescale_tap_c, prescale_tap_b, prescale_tap_a} = tap;

  serial_baud_divider_and_buffer u_serial_baud_divider_and_buffer (.*);

  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  // ticks counted here so the tasks only snapshot and compare
  always @(posedge aclk) if (baud5_tick === 1'b1) ticks <= ticks + 1;

  task chk(input [31:0] g, input [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task wr(input [31:0] a, input [7:0] d, input [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= !slow;
    // each channel is let go on its own handshake; only the watchdog ends a wait
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready !== 1'b1) s_axi_bready <= 1;
    end while (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1);
    s_axi_bready <= 0;
    chk(s_axi_bresp, er);
  endtask

  task rd(input [31:0] a, input [31:0] e, input [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= !slow;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1) s_axi_rready <= 1;
    end while (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1);
    s_axi_rready <= 0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
  endtask

  // wrong taps first must leave the count alone
  task div(input [7:0] c, input [7:0] k, input integer p, input integer e);
    integer t0;
    wr(FR, k, 0);
    wr(CT, c, 0);
    @(posedge aclk);
    t0 = ticks;
    tap <= ~(4'h1 << c[5:4]);
    repeat (p) @(posedge aclk);
    tap <= 4'h1 << c[5:4];
    repeat (p) @(posedge aclk);
    tap <= 0;
    repeat (3) @(posedge aclk);
    chk(ticks - t0, e);
  endtask

  task t_reset;
    rd(CT, 32'h0, 0);
    rd(FR, 32'h0, 0);
    rd(ST, 32'h22, 0);
  endtask

  task t_regs;
    // late bready/rready: response and read data must stand
    slow <= 1;
    wr(FR, 8'h0a, 0);
    rd(FR, 32'h0a, 0);
    slow <= 0;
    wr(CT, 8'h7f, 0);
    rd(CT, 32'h7f, 0);
    // lane 0 off: answered but nothing stored
    s_axi_wstrb <= 4'he;
    wr(CT, 8'h00, 0);
    s_axi_wstrb <= 4'hf;
    rd(CT, 32'h7f, 0);
    wr(32'h100, 8'h55, 2);
    rd(32'h100, 32'h0, 2);
  endtask

  task t_div;
    div(8'h02, 0, 8, 4);
    div(8'h10, 0, 32, 2);
    // n=1 only with the fraction off, as a uart channel would run it
    div(8'h21, 0, 16, 16);
    div(8'h73, 5, 59, 16);
    div(8'h73, 5, 58, 15);
    div(8'h4f, 15, 241, 16);
  endtask

  // fill channel 0 while the engine stalls, then drain in order
  task t_tx;
    for (i = 0; i < 16; i++) wr(A0, 8'h30 + i, 0);
    rd(ST, 32'h24, 0);
    @(posedge aclk) tx0_ready <= 1;
    for (i = 0; i < 16; i++) begin
      @(negedge aclk);
      chk({tx0_valid, tx0_data}, 9'h130 + i);
    end
    @(posedge aclk) tx0_ready <= 0;
    rd(ST, 32'h22, 0);
  endtask

  task t_rx;
    @(posedge aclk);
    rx0_data <= 8'h5a;
    rx5_data <= 8'ha5;
    rx0_valid <= 1;
    rx5_valid <= 1;
    @(posedge aclk);
    rx0_valid <= 0;
    rx5_valid <= 0;
    rd(ST, 32'h33, 0);
    rd(A0, 32'h5a, 0);
    rd(A5, 32'ha5, 0);
    rd(ST, 32'h22, 0);
    wr(A5, 8'h77, 0);
    @(negedge aclk) chk({tx5_valid, tx5_data}, 9'h177);
    @(posedge aclk) tx5_ready <= 1;
    @(posedge aclk) tx5_ready <= 0;
    @(negedge aclk) chk(tx5_valid, 0);
  endtask

  task stop_test;
    $display("errors=%0d tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far beyond the thousand or so cycles needed
  initial begin
    #200000;
    errors++;
    stop_test;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, tx0_ready, tx5_ready} = 0;
    {slow, rx0_valid, rx5_valid, tap, rx0_data, rx5_data} = 0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_regs;
    t_div;
    t_tx;
    t_rx;
    stop_test;
  end
endmodule // test_serial_baud_divider_and_buffer
`default_nettype wire
